// ---- core/spirq_top.sv ----
// interrupt, status, sync-busy and address match logic of the serial unit
//
// Notes on behaviour
// - a one written to an enable-set bit turns it on; zero ignored.
// - error flag rises on receive overflow; write one clears.
// - client with fall detect sets select-low flag on select falling edge.
// - receive-complete follows unread data; cleared by data read or rx off.
// - with address match on, first word of a frame is the address.
// - host sets transmit-complete when shifting ends, nothing queued.
// - client sets transmit-complete on select rise; with address match on, only after address hit.
// - data-empty tracks the empty transmit buffer; data writes clear it.
// - overflow sets status bit and the affected word reads as zero.
// - overflow bit shows the state of the next character to be read.
// - control-b write when enabled is busy until synced; rewrite errors.
// - enable changes hold enable busy bit until synchronisation finishes.
// - soft reset holds its busy bit; other register accesses are refused.
// - address modes: masked compare, two addresses, or inclusive range.
// - receiver disable flushes buffer, drops reception, clears overflow.
// - enable-clear bit disables interrupt; set and clear read alike.
`timescale 1ns/1ps

module spirq_top import spirq_pkg::*; (
  input  wire logic              clk,           // 250 MHz clock
  input  wire logic              rst_n,         // async reset, active low
  input  wire logic [ADDR_W-1:0] addr,          // register byte address
  input  wire logic [DATA_W-1:0] wdata,         // write data
  input  wire logic              wr_en,         // write strobe
  input  wire logic              rd_en,         // read strobe
  output logic      [DATA_W-1:0] rdata,         // read data, next cycle
  output logic                   bus_err,       // refused access pulse
  output logic                   irq,           // interrupt request level
  input  wire logic              ss_n,          // select pin, asynchronous
  input  wire logic              rx_avail,      // receive buffer not empty
  input  wire logic [WORD_W-1:0] rx_word,       // head of receive buffer
  input  wire logic              rx_word_ovf,   // head word overflowed
  input  wire logic              rx_ovf_evt,    // overflow detected pulse
  input  wire logic              rx_addr_stb,   // first word of frame pulse
  input  wire logic              tx_empty,      // transmit buffer can accept
  input  wire logic              tx_shift_done, // host shifting ended pulse
  input  wire logic [2:0]        sync_done,     // sync complete pulses
  output logic      [2:0]        sync_req,      // sync start pulses
  output logic                   unit_enable,   // unit enabled level
  output logic                   client_mode,   // client mode level
  output logic                   recv_enable,   // receiver enable level
  output logic                   rx_pop,        // pop receive buffer
  output logic                   rx_flush,      // flush receive buffer
  output logic                   tx_push,       // push transmit data
  output logic      [DATA_W-1:0] tx_data,       // transmit data
  output logic                   addr_hit       // frame began with a hit
);

  // ==========================================================
  // state record
  typedef struct packed {
    logic              ss_meta;
    logic              ss_sync;
    logic              ss_prev;
    logic [7:0]        ien;
    logic              f_err;
    logic              f_ssl;
    logic              f_rxc;
    logic              f_txc;
    logic              f_dre;
    logic              ovf;
    logic [2:0]        busy;
    logic              enable;
    logic              client;
    logic              receiver_enable;
    logic              receiver_enable_pend;
    logic              sfde;
    logic              amen;
    logic [1:0]        address_match_mode;
    logic [7:0]        am_addr;
    logic [7:0]        am_mask;
    logic              hit;
    logic [DATA_W-1:0] rdata;
    logic              bus_err;
    logic              rx_pop;
    logic              rx_flush;
    logic              tx_push;
    logic [DATA_W-1:0] tx_data;
    logic [2:0]        sync_req;
  } spirq_state_t;

  // select synchroniser starts at the idle-high level: no false edge
  localparam spirq_state_t ST_RESET = '{
    ss_meta: 1'b1,
    ss_sync: 1'b1,
    ss_prev: 1'b1,
    default: '0
  };

  spirq_state_t q;
  spirq_state_t d;

  // ==========================================================
  // reset release through two flops
  logic rst_meta_q;
  logic rst_sync_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  // ==========================================================
  // address comparison helpers
  logic [7:0] rx_addr;
  logic       am_match;
  logic [7:0] flags;
  logic [7:0] w8;

  assign rx_addr = rx_word[7:0];
  assign w8      = wdata[7:0];

  // compare the address word against the stored pair
  // three match modes
  always_comb begin
    unique case (spirq_address_match_mode_t'(q.address_match_mode))
      SPIRQ_AM_MASK:  am_match = ((rx_addr ^ q.am_addr) & ~q.am_mask)
                                 == BYTE_ZERO;
      SPIRQ_AM_TWO:   am_match = (rx_addr == q.am_addr) ||
                                 (rx_addr == q.am_mask);
      SPIRQ_AM_RANGE: am_match = (rx_addr <= q.am_addr) &&
                                 (rx_addr >= q.am_mask);
      SPIRQ_AM_RSVD:  am_match = 1'b0;
    endcase
  end

  // flag register image
  always_comb begin
    flags           = BYTE_ZERO;
    flags[FL_ERROR] = q.f_err;
    flags[FL_SSL]   = q.f_ssl;
    flags[FL_RXC]   = q.f_rxc;
    flags[FL_TXC]   = q.f_txc;
    flags[FL_DRE]   = q.f_dre;
  end

  // ==========================================================
  // access decode
  logic in_soft_reset;
  logic allow_acc;
  logic wr_ok;
  logic rd_ok;
  logic wr_a;
  logic wr_b;
  logic refuse_b;
  logic ss_fall;
  logic ss_rise;
  logic data_wr;
  logic data_rd;

  // only control-a passes while soft reset runs
  assign in_soft_reset  = q.busy[SB_SOFT_RESET];
  assign allow_acc = !in_soft_reset || (addr == OFS_CONTROL_A);
  assign wr_ok     = wr_en && allow_acc;
  assign rd_ok     = rd_en && allow_acc;
  assign wr_a      = wr_ok && (addr == OFS_CONTROL_A);
  // rewrite while control-b sync is busy is refused
  assign refuse_b  = wr_ok && (addr == OFS_CONTROL_B) && q.busy[SB_CONTROL_B];
  assign wr_b      = wr_ok && (addr == OFS_CONTROL_B) && !q.busy[SB_CONTROL_B];
  assign data_wr   = wr_ok && (addr == OFS_DATA);
  assign data_rd   = rd_ok && (addr == OFS_DATA);
  assign ss_fall   = q.ss_prev && !q.ss_sync;
  assign ss_rise   = !q.ss_prev && q.ss_sync;

  // ==========================================================
  // next state
  always_comb begin
    d          = q;
    d.ss_meta  = ss_n;
    d.ss_sync  = q.ss_meta;
    d.ss_prev  = q.ss_sync;
    d.bus_err  = (wr_en || rd_en) && !allow_acc || refuse_b;
    d.rx_pop   = 1'b0;
    d.rx_flush = 1'b0;
    d.tx_push  = 1'b0;
    d.sync_req = 3'b000;
    d.rdata    = WORD_ZERO;

    // read data mux, answered in the next cycle
    if (rd_ok) begin
      unique case (addr)
        OFS_CONTROL_A: begin
          d.rdata[CA_ENABLE] = q.enable;
          d.rdata[CA_CLIENT] = q.client;
        end
        OFS_CONTROL_B: begin
          d.rdata[CB_SFDE]               = q.sfde;
          d.rdata[CB_AMEN]               = q.amen;
          d.rdata[CB_ADDRESS_MATCH_MODE_H:CB_ADDRESS_MATCH_MODE_L] = q.address_match_mode;
          d.rdata[CB_RECEIVER_ENABLE]               = q.receiver_enable || q.receiver_enable_pend;
        end
        // both enable views read the same bits
        OFS_IEN_CLEAR, OFS_IEN_SET: d.rdata[7:0] = q.ien;
        OFS_FLAGS:     d.rdata[7:0] = flags;
        // overflow of the character waiting at the head
        OFS_STATUS:    d.rdata[ST_OVF] = q.ovf || (rx_avail && rx_word_ovf);
        OFS_SYNC_BUSY: d.rdata[2:0] = q.busy;
        OFS_ADDR_MATCH: begin
          d.rdata[AM_ADDR_H:AM_ADDR_L] = q.am_addr;
          d.rdata[AM_MASK_H:AM_MASK_L] = q.am_mask;
        end
        OFS_DATA: begin
          // an overflowed word reads as zero
          if (!rx_word_ovf) begin
            d.rdata[WORD_W-1:0] = rx_word;
          end
        end
        default: d.rdata = WORD_ZERO;
      endcase
    end

    // interrupt enable set and clear
    if (wr_ok && addr == OFS_IEN_SET) begin
      d.ien = q.ien | (w8 & FLAG_MASK);
    end
    if (wr_ok && addr == OFS_IEN_CLEAR) begin
      d.ien = q.ien & ~w8;
    end

    // control-a: enable and client mode, soft reset request
    if (wr_a) begin
      if (!q.enable) begin
        d.client = wdata[CA_CLIENT];
      end
      if (wdata[CA_ENABLE] != q.enable && !in_soft_reset) begin
        d.enable            = wdata[CA_ENABLE];
        d.busy[SB_ENABLE]   = 1'b1;
        d.sync_req[SB_ENABLE] = 1'b1;
      end
      // soft reset request holds its busy bit
      if (wdata[CA_SOFT_RESET]) begin
        d.busy[SB_SOFT_RESET]    = 1'b1;
        d.sync_req[SB_SOFT_RESET] = 1'b1;
      end
    end

    // control-b fields
    if (wr_b) begin
      d.sfde  = wdata[CB_SFDE];
      d.amen  = wdata[CB_AMEN];
      d.address_match_mode = wdata[CB_ADDRESS_MATCH_MODE_H:CB_ADDRESS_MATCH_MODE_L];
      if (!wdata[CB_RECEIVER_ENABLE]) begin
        // receiver off at once, flush and clear overflow
        d.receiver_enable      = 1'b0;
        d.receiver_enable_pend = 1'b0;
        d.rx_flush  = 1'b1;
        d.ovf       = 1'b0;
      end else if (!q.enable) begin
        d.receiver_enable = 1'b1;
      end else if (!q.receiver_enable) begin
        d.receiver_enable_pend = 1'b1;
      end
      if (q.enable) begin
        d.busy[SB_CONTROL_B]     = 1'b1;
        d.sync_req[SB_CONTROL_B] = 1'b1;
      end
    end

    // address register, locked while enabled
    if (wr_ok && addr == OFS_ADDR_MATCH && !q.enable) begin
      d.am_addr = wdata[AM_ADDR_H:AM_ADDR_L];
      d.am_mask = wdata[AM_MASK_H:AM_MASK_L];
    end

    // synchronisation completions
    if (sync_done[SB_CONTROL_B] && q.busy[SB_CONTROL_B]) begin
      d.busy[SB_CONTROL_B] = 1'b0;
      if (q.receiver_enable_pend && d.receiver_enable_pend) begin
        d.receiver_enable      = 1'b1;
        d.receiver_enable_pend = 1'b0;
      end
    end
    if (sync_done[SB_ENABLE]) begin
      d.busy[SB_ENABLE] = 1'b0;
    end

    // data register traffic
    if (data_wr) begin
      d.tx_push = 1'b1;
      d.tx_data = wdata;
    end
    if (data_rd && rx_avail) begin
      d.rx_pop = 1'b1;
    end

    // first word of a frame is judged as an address
    if (q.ss_sync) begin
      d.hit = 1'b0;
    end else if (rx_addr_stb && q.amen) begin
      d.hit = am_match;
    end

    d.f_rxc = rx_avail && q.receiver_enable && !data_rd && !(wr_b && !wdata[CB_RECEIVER_ENABLE]);

    // data-empty follows tx_empty, cleared by a data write, not by write-one
    d.f_dre = tx_empty && !data_wr;

    // sticky overflow status, event wins over clear
    if (wr_ok && addr == OFS_STATUS && wdata[ST_OVF]) begin
      d.ovf = 1'b0;
    end
    if (rx_ovf_evt && q.receiver_enable) begin
      d.ovf = 1'b1;
    end

    // error flag, set wins over write-one clear
    if (wr_ok && addr == OFS_FLAGS && w8[FL_ERROR]) begin
      d.f_err = 1'b0;
    end
    if (rx_ovf_evt && q.receiver_enable) begin
      d.f_err = 1'b1;
    end

    if (wr_ok && addr == OFS_FLAGS && w8[FL_SSL]) begin
      d.f_ssl = 1'b0;
    end
    if (q.client && q.sfde && ss_fall) begin
      d.f_ssl = 1'b1;
    end

    // transmit-complete clears on write-one or new data
    if ((wr_ok && addr == OFS_FLAGS && w8[FL_TXC]) || data_wr) begin
      d.f_txc = 1'b0;
    end
    // host sets it when shifting ends idle
    if (!q.client && tx_shift_done) begin
      d.f_txc = 1'b1;
    end
    // client sets it on select rise, after a hit if address match is on
    if (q.client && ss_rise && (!q.amen || q.hit)) begin
      d.f_txc = 1'b1;
    end

    // soft reset completion returns all to reset values, except the select synchroniser, the flush pulse and the bus error
    if (sync_done[SB_SOFT_RESET] && in_soft_reset) begin
      d          = ST_RESET;
      d.ss_meta  = ss_n;
      d.ss_sync  = q.ss_meta;
      d.ss_prev  = q.ss_sync;
      d.rx_flush = 1'b1;
      // an access refused in this very cycle still reports its error
      d.bus_err  = (wr_en || rd_en) && !allow_acc;
    end
  end

  // ==========================================================
  // state register
  // everything clears at reset, except the select synchroniser, which loads high
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      q <= ST_RESET;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  // any enabled flag raises the request
  assign irq         = |(flags & q.ien);
  assign rdata       = q.rdata;
  assign bus_err     = q.bus_err;
  assign sync_req    = q.sync_req;
  assign unit_enable = q.enable;
  assign client_mode = q.client;
  assign recv_enable = q.receiver_enable;
  assign rx_pop      = q.rx_pop;
  assign rx_flush    = q.rx_flush;
  assign tx_push     = q.tx_push;
  assign tx_data     = q.tx_data;
  assign addr_hit    = q.hit;

endmodule // spirq_top

// ---- core/spirq_pkg.sv ----
// constants and types of the serial unit interrupt and status block
package spirq_pkg;

  // ==========================================================
  // bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned WORD_W = 9;

  // ==========================================================
  // register offsets (byte addresses on the plain port)
  localparam logic [7:0] OFS_CONTROL_A  = 8'h00;
  localparam logic [7:0] OFS_CONTROL_B  = 8'h04;
  localparam logic [7:0] OFS_IEN_CLEAR  = 8'h14;
  localparam logic [7:0] OFS_IEN_SET    = 8'h16;
  localparam logic [7:0] OFS_FLAGS      = 8'h18;
  localparam logic [7:0] OFS_STATUS     = 8'h1a;
  localparam logic [7:0] OFS_SYNC_BUSY  = 8'h1c;
  localparam logic [7:0] OFS_ADDR_MATCH = 8'h24;
  localparam logic [7:0] OFS_DATA       = 8'h28;

  // ==========================================================
  // interrupt flag and enable bit positions
  localparam int unsigned FL_ERROR = 7;
  localparam int unsigned FL_SSL   = 3;
  localparam int unsigned FL_RXC   = 2;
  localparam int unsigned FL_TXC   = 1;
  localparam int unsigned FL_DRE   = 0;
  localparam logic [7:0]  FLAG_MASK = 8'h8f;

  // status, busy and control bit positions
  localparam int unsigned ST_OVF     = 2;
  localparam int unsigned SB_CONTROL_B   = 2;
  localparam int unsigned SB_ENABLE  = 1;
  localparam int unsigned SB_SOFT_RESET   = 0;
  localparam int unsigned CA_SOFT_RESET   = 0;
  localparam int unsigned CA_ENABLE  = 1;
  localparam int unsigned CA_CLIENT  = 2;
  localparam int unsigned CB_SFDE    = 9;
  localparam int unsigned CB_AMEN    = 12;
  localparam int unsigned CB_ADDRESS_MATCH_MODE_L = 14;
  localparam int unsigned CB_ADDRESS_MATCH_MODE_H = 15;
  localparam int unsigned CB_RECEIVER_ENABLE    = 17;
  localparam int unsigned AM_ADDR_L  = 0;
  localparam int unsigned AM_ADDR_H  = 7;
  localparam int unsigned AM_MASK_L  = 16;
  localparam int unsigned AM_MASK_H  = 23;

  // ==========================================================
  // client address match modes
  typedef enum logic [1:0] {
    SPIRQ_AM_MASK  = 2'h0,
    SPIRQ_AM_TWO   = 2'h1,
    SPIRQ_AM_RANGE = 2'h2,
    SPIRQ_AM_RSVD  = 2'h3
  } spirq_address_match_mode_t;

  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

endpackage

// ---- sim/spirq_checker.sv ----
// port-level checks of the interrupt, status and sync-busy block
`timescale 1ns/1ps

module spirq_checker import spirq_pkg::*; (
  input wire logic              clk,         // clock
  input wire logic              rst_n,       // async reset, active low
  input wire logic [ADDR_W-1:0] addr,        // register address
  input wire logic [DATA_W-1:0] wdata,       // write data
  input wire logic              wr_en,       // write strobe
  input wire logic              rd_en,       // read strobe
  input wire logic [DATA_W-1:0] rdata,       // read data
  input wire logic              bus_err,     // refused access
  input wire logic              ss_n,        // select pin
  input wire logic              rx_avail,    // unread word
  input wire logic              rx_word_ovf, // head word overflowed
  input wire logic [2:0]        sync_done,   // sync finished
  input wire logic [2:0]        sync_req,    // sync start
  input wire logic              recv_enable, // receiver on
  input wire logic              rx_pop,      // pop pulse
  input wire logic              rx_flush,    // flush pulse
  input wire logic              tx_push,     // push pulse
  input wire logic [DATA_W-1:0] tx_data,     // pushed data
  input wire logic              addr_hit     // frame address hit
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // select seen high long enough to cross the synchroniser
  sequence s_ss_idle;
    ss_n [*4];
  endsequence
  // a data register read while a word waits
  sequence s_data_rd;
    rd_en && addr == OFS_DATA && rx_avail;
  endsequence

  // bus answers and side effects tied to their causes
  a_rdata_idle: assert property (
    !$past(rd_en) |-> rdata == WORD_ZERO) else $error("stray read data");
  a_err_cause: assert property (
    bus_err |-> $past(wr_en || rd_en)) else $error("bus error unprompted");
  a_sync_cause: assert property (
    sync_req != 3'h0 |-> $past(wr_en) && ($past(addr) == OFS_CONTROL_A
    || $past(addr) == OFS_CONTROL_B)) else $error("sync without write");
  a_pop_read: assert property (
    s_data_rd |=> rx_pop || bus_err) else $error("data read did not pop");
  a_pop_cause: assert property (
    rx_pop |-> $past(rd_en && addr == OFS_DATA && rx_avail))
    else $error("pop without read");
  a_push_data: assert property (
    tx_push |-> $past(wr_en && addr == OFS_DATA) && tx_data == $past(wdata))
    else $error("bad transmit push");
  a_hit_idle: assert property (
    s_ss_idle |=> !addr_hit) else $error("address hit while deselected");
  a_flush_cause: assert property (
    rx_flush |-> $past(wr_en) || $past(sync_done[0]) || $past(sync_done[2]))
    else $error("flush unprompted");
  a_receiver_enable_cause: assert property (
    $rose(recv_enable) |-> $past(wr_en) || $past(sync_done[2]))
    else $error("receiver enabled unprompted");
  a_ovf_zero: assert property (
    $past(rd_en && addr == OFS_DATA && rx_word_ovf) |-> rdata == WORD_ZERO)
    else $error("overflowed word not zero");
endmodule // spirq_checker

bind spirq_top spirq_checker i_spirq_checker (.*);

// ---- sim/spirq_tb_top.sv ----
// self-checking bench of the interrupt, status and sync-busy block
`timescale 1ns/1ps

module spirq_tb_top import spirq_pkg::*;;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wdata = WORD_ZERO;
  logic              wr_en = 1'b0, rd_en = 1'b0, ss_n = 1'b1;
  logic              rx_avail = 1'b0, rx_word_ovf = 1'b0, rx_ovf_evt = 1'b0;
  logic              rx_addr_stb = 1'b0, tx_empty = 1'b0;
  logic              tx_shift_done = 1'b0;
  logic [WORD_W-1:0] rx_word = 9'h000;
  logic [2:0]        sync_done = 3'h0;
  logic [DATA_W-1:0] rdata, tx_data;
  logic [2:0]        sync_req;
  logic              bus_err, irq, unit_enable, client_mode, recv_enable;
  logic              rx_pop, rx_flush, tx_push, addr_hit;
  int                num_errors = 0, comparisons = 0;

  spirq_top i_spirq_top (.*);

  // 250 MHz clock
  always #2 clk = ~clk;

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one-cycle write, outputs settled on return
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask

  // one-cycle read, data judged in the following cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] e, string nm);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(nm, rdata, e);
  endtask

  task automatic done(input int b);
    @(posedge clk);
    sync_done[b] <= 1'b1;
    @(posedge clk);
    sync_done <= 3'h0;
    #1;
  endtask

  task automatic t_reset;
    rd(OFS_FLAGS, WORD_ZERO, "flags");
    rd(OFS_STATUS, WORD_ZERO, "status");
    rd(OFS_SYNC_BUSY, WORD_ZERO, "busy");
    rd(OFS_IEN_SET, WORD_ZERO, "ien");
    rd(8'h3c, WORD_ZERO, "unmapped");
    wr(OFS_ADDR_MATCH, 32'h0010_0020);
    rd(OFS_ADDR_MATCH, 32'h0010_0020, "addr");
  endtask

  task automatic t_enables;
    wr(OFS_IEN_SET, 32'h0000_008f);
    rd(OFS_IEN_CLEAR, 32'h0000_008f, "ien_clr");
    wr(OFS_IEN_SET, WORD_ZERO);
    wr(OFS_IEN_CLEAR, 32'h0000_000c);
    rd(OFS_IEN_SET, 32'h0000_0083, "ien_set");
    wr(OFS_IEN_CLEAR, 32'h0000_008f);
    rd(OFS_IEN_SET, WORD_ZERO, "ien_off");
  endtask

  task automatic t_dre;
    @(posedge clk);
    tx_empty <= 1'b1;
    rd(OFS_FLAGS, 32'h0000_0001, "dre");
    chk("irq_masked", irq, 0);
    wr(OFS_IEN_SET, 32'h0000_0001);
    chk("irq", irq, 1);
    wr(OFS_FLAGS, 32'h0000_0001);
    rd(OFS_FLAGS, 32'h0000_0001, "dre_w1");
    wr(OFS_DATA, 32'hcafe_0123);
    chk("tx_push", tx_push, 1);
    chk("tx_data", tx_data, 32'hcafe_0123);
    @(posedge clk);
    tx_empty <= 1'b0;
    rd(OFS_FLAGS, WORD_ZERO, "dre_off");
    chk("irq_off", irq, 0);
    wr(OFS_IEN_CLEAR, 32'h0000_0001);
  endtask

  task automatic t_txc;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      tx_shift_done <= 1'b1;
      @(posedge clk);
      tx_shift_done <= 1'b0;
      rd(OFS_FLAGS, 32'h0000_0002, "txc");
      wr(i ? OFS_DATA : OFS_FLAGS, 32'h0000_0002);
      rd(OFS_FLAGS, WORD_ZERO, "txc_clr");
    end
  endtask

  task automatic t_rx;
    wr(OFS_CONTROL_B, 32'h0002_0000);
    chk("recv_enable", recv_enable, 1);
    @(posedge clk);
    rx_avail <= 1'b1;
    rx_word <= 9'h1a5;
    rd(OFS_FLAGS, 32'h0000_0004, "rxc");
    wr(OFS_FLAGS, 32'h0000_0004);
    rd(OFS_FLAGS, 32'h0000_0004, "rxc_w1");
    rd(OFS_DATA, 32'h0000_01a5, "data");
    chk("rx_pop", rx_pop, 1);
    @(posedge clk);
    rx_ovf_evt <= 1'b1;
    rx_word_ovf <= 1'b1;
    @(posedge clk);
    rx_ovf_evt <= 1'b0;
    rd(OFS_STATUS, 32'h0000_0004, "ovf");
    rd(OFS_FLAGS, 32'h0000_0084, "error");
    rd(OFS_DATA, WORD_ZERO, "ovf_data");
    wr(OFS_CONTROL_B, WORD_ZERO);
    chk("rx_flush", rx_flush, 1);
    rd(OFS_FLAGS, 32'h0000_0080, "rxc_off");
    @(posedge clk);
    rx_avail <= 1'b0;
    rx_word_ovf <= 1'b0;
    rd(OFS_STATUS, WORD_ZERO, "ovf_off");
    wr(OFS_FLAGS, 32'h0000_0080);
    rd(OFS_FLAGS, WORD_ZERO, "err_clr");
  endtask

  // one select frame with an address word, then the flags judged
  task automatic frame(input logic [8:0] w, input logic hit,
                       input logic [31:0] fl);
    @(posedge clk);
    ss_n <= 1'b0;
    cyc(4);
    rx_addr_stb <= 1'b1;
    rx_word <= w;
    cyc(1);
    rx_addr_stb <= 1'b0;
    cyc(2);
    #1;
    chk("addr_hit", addr_hit, hit);
    ss_n <= 1'b1;
    cyc(5);
    rd(OFS_FLAGS, fl, "ssl_txc");
    wr(OFS_FLAGS, 32'h0000_000a);
  endtask

  task automatic t_client;
    wr(OFS_CONTROL_A, 32'h0000_0006);
    chk("sync_req", sync_req, 3'h2);
    rd(OFS_SYNC_BUSY, 32'h0000_0002, "busy_en");
    done(1);
    rd(OFS_SYNC_BUSY, WORD_ZERO, "busy_en0");
    chk("enable", unit_enable && client_mode, 1);
    wr(OFS_CONTROL_B, 32'h0000_9200);
    rd(OFS_SYNC_BUSY, 32'h0000_0004, "busy_b");
    wr(OFS_CONTROL_B, WORD_ZERO);
    chk("bus_err", bus_err, 1);
    done(2);
    rd(OFS_SYNC_BUSY, WORD_ZERO, "busy_b0");
    // inclusive range 0x10 to 0x20
    frame(9'h021, 1'b0, 32'h0000_0008);
    frame(9'h020, 1'b1, 32'h0000_000a);
    // masked compare, mask bit 4 is a don't-care
    wr(OFS_CONTROL_B, 32'h0000_1200);
    done(2);
    frame(9'h030, 1'b1, 32'h0000_000a);
    frame(9'h028, 1'b0, 32'h0000_0008);
    // two addresses, the mask field is the second one
    wr(OFS_CONTROL_B, 32'h0000_5200);
    done(2);
    frame(9'h010, 1'b1, 32'h0000_000a);
    frame(9'h011, 1'b0, 32'h0000_0008);
    // reserved mode never matches
    wr(OFS_CONTROL_B, 32'h0000_d200);
    done(2);
    frame(9'h020, 1'b0, 32'h0000_0008);
    rd(OFS_FLAGS, WORD_ZERO, "ssl_clr");
  endtask

  task automatic t_soft_reset;
    wr(OFS_CONTROL_A, 32'h0000_0003);
    chk("sync_req", sync_req, 3'h1);
    rd(OFS_FLAGS, WORD_ZERO, "refused");
    chk("bus_err", bus_err, 1);
    done(0);
    chk("rx_flush", rx_flush, 1);
    chk("enable", unit_enable, 0);
    rd(OFS_SYNC_BUSY, WORD_ZERO, "busy");
    rd(OFS_ADDR_MATCH, WORD_ZERO, "addr");
  endtask

  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // reset, then the scenarios in turn
  initial begin
    cyc(6);
    rst_n <= 1'b1;
    cyc(3);
    t_reset;
    t_enables;
    t_dre;
    t_txc;
    t_rx;
    t_client;
    t_soft_reset;
    report_and_stop;
  end

  // watchdog, well beyond the few hundred cycles the scenarios need
  initial begin
    #20000;
    num_errors++;
    report_and_stop;
  end
endmodule // spirq_tb_top
